// ### design/predriver_ctrl.v
// Channel control and supervision of the eight-channel pre-driver
`timescale 1ns/1ps
`default_nettype none
`include "predriver_regs.vh"

module predriver_ctrl
(
    // Clock and power-on reset
    input  wire       ref_clk,
    input  wire       rst_n,
    // Asynchronous pins and comparators
    input  wire       external_reset_n,
    input  wire       channel6_enable_pin,
    input  wire [7:0] channel_on_pin_n,
    input  wire       pumpUvComp,
    input  wire       sdoOvComp,
    input  wire       ncsPin,
    input  wire       sdoDrive,
    // Configuration bits from serial interface
    input  wire [7:0] channel_output_enable,
    input  wire [7:0] serial_channel_on,
    input  wire [7:0] control_source_select,
    input  wire [7:0] side_select,
    input  wire [7:0] fet_type_select,
    input  wire [15:0] gate_current_select,
    input  wire       cfgWrite,
    // Read-clear strobes from serial interface
    input  wire       rdPumpUv,
    input  wire       rdSdoOv,
    input  wire       rdPor,
    input  wire       rdExtReset,
    input  wire       rdCh6,
    // Status
    output wire       pump_undervoltage_latch,
    output wire       pump_undervoltage_state,
    output wire       serial_out_overvoltage_latch,
    output wire       porLatch,
    output wire       external_reset_latch,
    output wire       channel6_pin_state,
    output wire       channel6_disable_latch,
    output reg        internalReset,
    // Analogue controls
    output reg        pumpEnable,
    output reg        openLoadRegEnable,
    output reg        sdoEnable,
    output reg  [7:0] chanDriveOn,
    output reg  [7:0] chanThreeState,
    output reg  [7:0] chanHighSide,
    output reg  [7:0] chanPChannel,
    output reg  [7:0] gateExtResistor,
    output reg  [15:0] gateCurrentLevel
);

    // ----------------------------------------
    // Input synchronisation
    // ----------------------------------------
    wire       extResetSync;
    wire       ch6PinSync;
    wire       pumpUvSync;
    wire       sdoOvSync;
    wire       ncsSync;
    wire [7:0] onPinSync;

    // External reset idles high after reset so a floating pin is inactive
    reg extRst1_q;
    reg extRst2_q;
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            extRst1_q <= 1'h1;
            extRst2_q <= 1'h1;
        end
        else
        begin
            extRst1_q <= external_reset_n;
            extRst2_q <= extRst1_q;
        end
    end
    assign extResetSync = extRst2_q;

    sync2 uCh6 (.ref_clk(ref_clk), .rst_n(rst_n), .asyncIn(channel6_enable_pin), .syncOut(ch6PinSync));
    sync2 uPumpUv (.ref_clk(ref_clk), .rst_n(rst_n), .asyncIn(pumpUvComp), .syncOut(pumpUvSync));
    sync2 uSdoOv (.ref_clk(ref_clk), .rst_n(rst_n), .asyncIn(sdoOvComp), .syncOut(sdoOvSync));
    // Select synchronised inverted so its reset value matches the idle level
    wire ncsSelSync;
    sync2 uNcs (.ref_clk(ref_clk), .rst_n(rst_n), .asyncIn(~ncsPin), .syncOut(ncsSelSync));
    assign ncsSync = ~ncsSelSync;

    genvar gi;
    generate
        for (gi = 0; gi < `NUM_CHANNELS; gi = gi + 1)
        begin : gOnPin
            sync2 uOn (.ref_clk(ref_clk), .rst_n(rst_n), .asyncIn(channel_on_pin_n[gi]),
                       .syncOut(onPinSync[gi]));
        end
    endgenerate

    // ----------------------------------------
    // Internal reset
    // ----------------------------------------
    wire extResetActive = ~extResetSync;

    // OR of power-on and external reset, registered
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            internalReset <= 1'h1;
        else
            internalReset <= extResetActive;
    end

    // Charge pump and open-load regulators only after both resets released
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pumpEnable        <= 1'h0;
            openLoadRegEnable <= 1'h0;
        end
        else
        begin
            pumpEnable        <= ~extResetActive;
            openLoadRegEnable <= ~extResetActive;
        end
    end

    // ----------------------------------------
    // Pump undervoltage filter
    // ----------------------------------------
    localparam integer UV_FILT_CYC = `PUMP_UV_FILT_CYC;
    localparam [9:0]   UV_FILT     = UV_FILT_CYC[9:0];
    reg [9:0] uvCnt_q;
    reg       uvFilt_q;
    reg       uvFiltPrev_q;

    // Filtered comparator: must persist for the filter time
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            uvCnt_q      <= 10'h000;
            uvFilt_q     <= 1'h0;
            uvFiltPrev_q <= 1'h0;
        end
        else
        begin
            uvFiltPrev_q <= uvFilt_q;
            if (internalReset || !pumpUvSync)
            begin
                uvCnt_q  <= 10'h000;
                uvFilt_q <= 1'h0;
            end
            else if (uvCnt_q < UV_FILT - 10'h001)
                uvCnt_q <= uvCnt_q + 10'h001;
            else
                uvFilt_q <= 1'h1;
        end
    end

    assign pump_undervoltage_state = pumpUvSync;

    wire uvRise = uvFilt_q & ~uvFiltPrev_q;

    // ----------------------------------------
    // Status latches (sticky, read clears)
    // ----------------------------------------
    wire ch6DisableEvent;
    wire sdoOvEvent;
    reg  porSeen_q;
    reg  extLatchClr;

    // One-shot after power-on reset release
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            porSeen_q <= 1'h0;
        else
            porSeen_q <= 1'h1;
    end

    // External reset latch cleared only by its read strobe, not by internal reset
    always @*
    begin
        extLatchClr = rdExtReset;
    end

    sticky_flag uPumpUvL (.ref_clk(ref_clk), .rst_n(rst_n), .setEvent(uvRise),
                          .readClear(rdPumpUv | internalReset), .flag(pump_undervoltage_latch));
    sticky_flag uSdoOvL (.ref_clk(ref_clk), .rst_n(rst_n), .setEvent(sdoOvEvent),
                         .readClear(rdSdoOv | internalReset), .flag(serial_out_overvoltage_latch));
    sticky_flag uPorL (.ref_clk(ref_clk), .rst_n(rst_n), .setEvent(~porSeen_q),
                       .readClear(rdPor), .flag(porLatch));
    sticky_flag uExtL (.ref_clk(ref_clk), .rst_n(rst_n), .setEvent(extResetActive),
                       .readClear(extLatchClr), .flag(external_reset_latch));
    sticky_flag uCh6L (.ref_clk(ref_clk), .rst_n(rst_n), .setEvent(ch6DisableEvent),
                       .readClear(rdCh6 | internalReset), .flag(channel6_disable_latch));

    assign channel6_pin_state = ch6PinSync;

    // ----------------------------------------
    // SDO overvoltage protection
    // ----------------------------------------
    reg ncsPrev_q;
    reg ovPrev_q;
    reg sdoOff_q;

    // Driver off on overvoltage, back on at NCS rise once clear
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ncsPrev_q <= 1'h1;
            ovPrev_q  <= 1'h0;
            sdoOff_q  <= 1'h0;
        end
        else
        begin
            ncsPrev_q <= ncsSync;
            ovPrev_q  <= sdoOvSync;
            if (sdoOvSync)
                sdoOff_q <= 1'h1;
            else if (ncsSync && !ncsPrev_q)
                sdoOff_q <= 1'h0;
        end
    end
    assign sdoOvEvent = sdoOvSync & ~ovPrev_q;

    // SDO enable: low-active select, not off, and caller drives
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            sdoEnable <= 1'h0;
        else
            sdoEnable <= sdoDrive & ~ncsSync & ~sdoOff_q & ~sdoOvSync;
    end

    // ----------------------------------------
    // Channel configuration registers
    // ----------------------------------------
    reg [7:0]  enable_q;
    reg [7:0]  side_q;
    reg [7:0]  fet_q;
    reg [15:0] gcc_q;

    // Captured on write; reset restores defaults
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            enable_q <= 8'h00;
            side_q   <= {8{`SIDE_LOW}};
            fet_q    <= {8{`FET_NCHANNEL}};
            gcc_q    <= {8{`GCC_RESET}};
        end
        else if (internalReset)
        begin
            enable_q <= 8'h00;
            side_q   <= {8{`SIDE_LOW}};
            fet_q    <= {8{`FET_NCHANNEL}};
            gcc_q    <= {8{`GCC_RESET}};
        end
        else if (cfgWrite)
        begin
            enable_q <= channel_output_enable;
            side_q   <= side_select;
            fet_q    <= fet_type_select;
            gcc_q    <= gate_current_select;
        end
    end

    // ----------------------------------------
    // Channel-6 gating
    // ----------------------------------------
    reg ch6EffPrev_q;
    wire [7:0] chanEnabled;

    assign chanEnabled = enable_q & ~(8'h01 << `CH6_INDEX)
                       | ({7'h00, enable_q[`CH6_INDEX] & ch6PinSync} << `CH6_INDEX);

    // Disable by pin while enable bit set
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            ch6EffPrev_q <= 1'h0;
        else
            ch6EffPrev_q <= chanEnabled[`CH6_INDEX];
    end
    assign ch6DisableEvent = ch6EffPrev_q & ~ch6PinSync & enable_q[`CH6_INDEX];

    // ----------------------------------------
    // Output control
    // ----------------------------------------
    reg [7:0]  onCmd;
    reg [15:0] gccLevel;
    reg [7:0]  gccExt;
    integer    k;

    // Source mux, polarity and gate-current decode per channel
    always @*
    begin
        onCmd    = 8'h00;
        gccLevel = 16'h0000;
        gccExt   = 8'h00;
        for (k = 0; k < `NUM_CHANNELS; k = k + 1)
        begin
            if (control_source_select[k])
                onCmd[k] = serial_channel_on[k];
            else
                onCmd[k] = ~onPinSync[k];
            case (gcc_q[2*k +: 2])
                `GCC_EXT_RES: gccExt[k] = 1'h1;
                `GCC_HIGH:    gccLevel[2*k +: 2] = 2'h1;
                `GCC_MID:     gccLevel[2*k +: 2] = 2'h2;
                `GCC_LOW:     gccLevel[2*k +: 2] = 2'h3;
                default:      gccExt[k] = 1'h1;
            endcase
        end
    end

    // Registered drive outputs, forced off on reset or pump undervoltage
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            chanDriveOn      <= 8'h00;
            chanThreeState   <= 8'hFF;
            chanHighSide     <= 8'h00;
            chanPChannel     <= 8'h00;
            gateExtResistor  <= 8'hFF;
            gateCurrentLevel <= 16'h0000;
        end
        else
        begin
            chanThreeState   <= internalReset ? 8'hFF : ~chanEnabled;
            chanDriveOn      <= (internalReset || uvFilt_q) ? 8'h00
                              : (onCmd & chanEnabled);
            chanHighSide     <= side_q;
            chanPChannel     <= fet_q;
            gateExtResistor  <= gccExt;
            gateCurrentLevel <= gccLevel;
        end
    end

endmodule // predriver_ctrl

`default_nettype wire

// ### design/predriver_regs.vh
// Constants for the pre-driver channel control and supervision logic
// How it works
// - Pump undervoltage forces outputs off, latches
// - Live pump undervoltage state is readable
// - Pump enabled after supply good, reset released
// - SDO overvoltage disables driver, re-enable at NCS
// - Below power-on threshold: reset, three-state, pump off
// - Above threshold logic runs, outputs follow control
// - External reset active low, pulled up internally
// - Reset latches set, cleared only by read
// - Internal reset is OR of both sources
// - Reset default: low-side N-FET, outputs three-stated
// - Any reset disables outputs, clears diagnostics
// - Eight channels, side and FET type selectable
// - Channel 6 needs enable bit AND pin
// - Channel 6 pin state readable, disable latched
// - Per-channel source: pin or serial bit
// - Pin active low, serial bit active high
// - Gate current code decoded, 00 external resistor
`ifndef PREDRIVER_REGS_VH
`define PREDRIVER_REGS_VH

// ----------------------------------------
// Geometry
// ----------------------------------------
`define NUM_CHANNELS      8
`define CH6_INDEX         5

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SIDE_LOW          1'h0
`define FET_NCHANNEL      1'h0
`define GCC_RESET         2'h0

// ----------------------------------------
// Gate current codes
// ----------------------------------------
`define GCC_EXT_RES       2'h0
`define GCC_HIGH          2'h1
`define GCC_MID           2'h2
`define GCC_LOW           2'h3

// ----------------------------------------
// Timing (pump undervoltage filter, ns)
// ----------------------------------------
`define CLK_PERIOD_NS     50
`define PUMP_UV_FILT_NS   10000
`define PUMP_UV_FILT_CYC  ((`PUMP_UV_FILT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### design/sync2.v
// Two-flop synchroniser for one asynchronous level
`timescale 1ns/1ps
`default_nettype none

module sync2
(
    // Clock and reset
    input  wire ref_clk,
    input  wire rst_n,
    // Data
    input  wire asyncIn,
    output wire syncOut
);

    reg stage1_q;
    reg stage2_q;

    // Two stages, first read only by second
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stage1_q <= 1'h0;
            stage2_q <= 1'h0;
        end
        else
        begin
            stage1_q <= asyncIn;
            stage2_q <= stage1_q;
        end
    end

    assign syncOut = stage2_q;

endmodule // sync2

`default_nettype wire

// ### design/sticky_flag.v
// Sticky status flag, set wins over read clear
`timescale 1ns/1ps
`default_nettype none

module sticky_flag
(
    // Clock and reset
    input  wire ref_clk,
    input  wire rst_n,
    // Control
    input  wire setEvent,
    input  wire readClear,
    output wire flag
);

    reg flag_q;

    // Set dominates clear on the same edge
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            flag_q <= 1'h0;
        else if (setEvent)
            flag_q <= 1'h1;
        else if (readClear)
            flag_q <= 1'h0;
    end

    assign flag = flag_q;

endmodule // sticky_flag

`default_nettype wire

// ### verif/predriver_ctrl_props.sv
// Assertion checker for the pre-driver control block
`timescale 1ns/1ps
`default_nettype none

module predriver_ctrl_props
(
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        rst_n,
    // Inputs
    input wire logic        pumpUvComp,
    input wire logic        rdPumpUv,
    // Status
    input wire logic        pump_undervoltage_latch,
    input wire logic        pump_undervoltage_state,
    input wire logic        serial_out_overvoltage_latch,
    input wire logic        external_reset_latch,
    input wire logic        channel6_pin_state,
    input wire logic        internalReset,
    // Drive controls
    input wire logic        pumpEnable,
    input wire logic        sdoEnable,
    input wire logic [7:0]  chanDriveOn,
    input wire logic [7:0]  chanThreeState,
    input wire logic [15:0] gateCurrentLevel,
    input wire logic [7:0]  gateExtResistor
);
    // ------
    // Properties
    // ------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_uv_drive_off: assert property ($rose(pump_undervoltage_latch) |-> chanDriveOn == 8'h00)
        else $error("Drive on after pump undervoltage");
    a_uv_state_live: assert property (pumpUvComp [*4] |-> pump_undervoltage_state)
        else $error("Pump state not following comparator");
    a_uv_latch_hold: assert property (pump_undervoltage_latch && !rdPumpUv && !internalReset
        |=> pump_undervoltage_latch)
        else $error("Pump latch lost without read");
    a_pump_off_rst: assert property (internalReset && $past(internalReset) |-> !pumpEnable)
        else $error("Pump enabled during reset");
    a_rst_outputs_off: assert property (internalReset && $past(internalReset)
        |-> chanThreeState == 8'hFF && chanDriveOn == 8'h00)
        else $error("Outputs active during reset");
    a_ext_latch_set: assert property ($rose(internalReset) |-> ##[0:2] external_reset_latch)
        else $error("External reset latch not set");
    a_sdo_ov_off: assert property ($rose(serial_out_overvoltage_latch) |-> !sdoEnable)
        else $error("Serial out driven during overvoltage");
    a_ch6_pin_and: assert property ($fell(channel6_pin_state) |-> ##[0:2] !chanDriveOn[5])
        else $error("Channel 6 on with pin low");
    a_gcc_ext_res: assert property (gateCurrentLevel[1:0] != 2'h0 |-> !gateExtResistor[0])
        else $error("External resistor with fixed current");

    // Main scenarios reached
    c_uv: cover property ($rose(pump_undervoltage_latch));
    c_ov: cover property ($rose(serial_out_overvoltage_latch));
    c_on: cover property ($fell(chanThreeState[0]));
endmodule // predriver_ctrl_props

bind predriver_ctrl predriver_ctrl_props props_i
(
    .ref_clk(ref_clk), .rst_n(rst_n), .pumpUvComp(pumpUvComp), .rdPumpUv(rdPumpUv),
    .pump_undervoltage_latch(pump_undervoltage_latch), .pump_undervoltage_state(pump_undervoltage_state),
    .serial_out_overvoltage_latch(serial_out_overvoltage_latch), .external_reset_latch(external_reset_latch),
    .channel6_pin_state(channel6_pin_state), .internalReset(internalReset), .pumpEnable(pumpEnable),
    .sdoEnable(sdoEnable), .chanDriveOn(chanDriveOn), .chanThreeState(chanThreeState),
    .gateCurrentLevel(gateCurrentLevel), .gateExtResistor(gateExtResistor)
);
`default_nettype wire

// ### verif/mcu_model.sv
// Microcontroller model framing chip select with a gated link clock
`timescale 1ns/1ps
`default_nettype none

module mcu_model
#(
    parameter FRAME_BITS = 32
)
(
    // Request from bench
    input  wire logic frameGo,
    // Link pins
    output var  logic ncsPin,
    output var  logic linkClk,
    output var  logic frameBusy
);
    // Select low, link clock runs only inside a frame
    initial
    begin
        ncsPin    = 1'b1;
        linkClk   = 1'b0;
        frameBusy = 1'b0;
        forever
        begin
            @(posedge frameGo);
            #10;
            frameBusy = 1'b1;
            ncsPin    = 1'b0;
            repeat (FRAME_BITS)
            begin
                #200 linkClk = 1'b1;
                #200 linkClk = 1'b0;
            end
            ncsPin    = 1'b1;
            frameBusy = 1'b0;
        end
    end
endmodule // mcu_model
`default_nettype wire

// ### verif/predriver_ctrl_tb.sv
// Self-checking bench for the pre-driver control block
`timescale 1ns/1ps
`default_nettype none

module predriver_ctrl_tb;
    // ------
    // Signals
    // ------
    logic        ref_clk, rst_n, extRstN, ch6Pin, uvComp, ovComp, sdoReq, cfgWr, frameGo;
    logic [4:0]  rdVec;
    logic [7:0]  onPinN, outEn, serOn, srcSel, sideSel, fetSel;
    logic [15:0] gccSel;
    wire         ncsPin, frameBusy, uvLatch, uvState, ovLatch, porLatch, extLatch, ch6State, ch6Latch;
    wire         intRst, pumpEn, olEn, sdoEn;
    wire  [7:0]  driveOn, triState, highSide, pChan, extRes;
    wire  [15:0] gccLvl;
    int          n_mismatch, checks_done;

    predriver_ctrl dut
    (
        .ref_clk(ref_clk), .rst_n(rst_n), .external_reset_n(extRstN), .channel6_enable_pin(ch6Pin),
        .channel_on_pin_n(onPinN), .pumpUvComp(uvComp), .sdoOvComp(ovComp), .ncsPin(ncsPin),
        .sdoDrive(sdoReq), .channel_output_enable(outEn), .serial_channel_on(serOn),
        .control_source_select(srcSel), .side_select(sideSel), .fet_type_select(fetSel),
        .gate_current_select(gccSel), .cfgWrite(cfgWr), .rdPumpUv(rdVec[0]), .rdSdoOv(rdVec[1]),
        .rdPor(rdVec[2]), .rdExtReset(rdVec[3]), .rdCh6(rdVec[4]), .pump_undervoltage_latch(uvLatch),
        .pump_undervoltage_state(uvState), .serial_out_overvoltage_latch(ovLatch), .porLatch(porLatch),
        .external_reset_latch(extLatch), .channel6_pin_state(ch6State), .channel6_disable_latch(ch6Latch),
        .internalReset(intRst), .pumpEnable(pumpEn), .openLoadRegEnable(olEn), .sdoEnable(sdoEn),
        .chanDriveOn(driveOn), .chanThreeState(triState), .chanHighSide(highSide), .chanPChannel(pChan),
        .gateExtResistor(extRes), .gateCurrentLevel(gccLvl)
    );

    mcu_model mcu (.frameGo(frameGo), .ncsPin(ncsPin), .linkClk(), .frameBusy(frameBusy));

    // Clock
    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // ------
    // Tasks
    // ------
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        checks_done++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("FAIL %0t %s: saw %h expected %h", $time, what, seen, exp);
        end
    endtask

    // Configuration write, then let it land
    task automatic cfg(input logic [7:0] en, side, fet, input logic [15:0] gcc);
        @(posedge ref_clk);
        outEn   <= en;
        sideSel <= side;
        fetSel  <= fet;
        gccSel  <= gcc;
        cfgWr   <= 1'b1;
        @(posedge ref_clk);
        cfgWr   <= 1'b0;
        tick(3);
    endtask

    // Live control sources
    task automatic ctl(input logic [7:0] src, on, pins);
        @(posedge ref_clk);
        srcSel <= src;
        serOn  <= on;
        onPinN <= pins;
        tick(5);
    endtask

    // Read-clear strobes
    task automatic clr(input logic [4:0] m);
        @(posedge ref_clk);
        rdVec <= m;
        @(posedge ref_clk);
        rdVec <= 5'h00;
        tick(2);
    endtask

    // One chip-select frame, serial-out enable checked while selected
    task automatic frame(input logic expSdo);
        int i;
        @(posedge ref_clk);
        frameGo <= 1'b1;
        tick(2);
        frameGo <= 1'b0;
        tick(20);
        chk(sdoEn, expSdo, "sdo in frame");
        for (i = 0; i < 1000 && frameBusy !== 1'b0; i++)
            tick(1);
        if (i == 1000)
        begin
            n_mismatch++;
            give_verdict();
        end
    endtask

    task automatic give_verdict;
        $display("Checks %0d, mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // ------
    // Sequence
    // ------
    initial
    begin
        {rst_n, cfgWr, frameGo, uvComp, ovComp, rdVec} = '0;
        {extRstN, ch6Pin, sdoReq} = 3'h7;
        {onPinN, outEn, serOn, srcSel, sideSel, fetSel, gccSel} = {8'hFF, 56'h0};
        n_mismatch  = 0;
        checks_done = 0;
        tick(2);
        rst_n <= 1'b1;
        tick(4);
        chk(triState, 8'hFF, "reset three-state");
        chk({highSide, pChan}, 16'h0000, "reset low-side N");
        chk(intRst, 1'b0, "reset released");
        chk(pumpEn, 1'b1, "pump on");
        chk(porLatch, 1'b1, "power-on latch");
        clr(5'h04);
        chk(porLatch, 1'b0, "power-on clear");
        $display("Test reset done");

        cfg(8'hFF, 8'h0F, 8'h03, 16'hE4E4);
        ctl(8'hFF, 8'hA5, 8'hFF);
        chk(triState, 8'h00, "enabled");
        chk(driveOn, 8'hA5, "serial on");
        chk({highSide, pChan}, 16'h0F03, "side and type");
        chk(extRes, 8'h11, "ext resistor");
        chk(gccLvl, 16'hE4E4, "current codes");
        ctl(8'h00, 8'hFF, 8'h3C);
        chk(driveOn, 8'hC3, "pin on");
        ctl(8'hF0, 8'hF0, 8'hF0);
        chk(driveOn, 8'hFF, "mixed sources on");
        ctl(8'hF0, 8'h0F, 8'h0F);
        chk(driveOn, 8'h00, "mixed sources off");
        $display("Test control done");

        ctl(8'hFF, 8'hFF, 8'hFF);
        @(posedge ref_clk);
        ch6Pin <= 1'b0;
        tick(5);
        chk(driveOn, 8'hDF, "ch6 pin low");
        chk({ch6State, ch6Latch}, 2'h1, "ch6 state");
        ch6Pin <= 1'b1;
        tick(5);
        chk({driveOn, ch6Latch}, 9'h1FF, "ch6 back");
        clr(5'h10);
        chk(ch6Latch, 1'b0, "ch6 clear");
        $display("Test channel 6 done");

        uvComp <= 1'b1;
        tick(5);
        chk({uvState, driveOn}, 9'h1FF, "uv filtering");
        tick(205);
        chk({uvLatch, driveOn}, 9'h100, "uv off");
        uvComp <= 1'b0;
        tick(10);
        chk({uvState, uvLatch}, 2'h1, "uv held");
        clr(5'h01);
        chk(uvLatch, 1'b0, "uv clear");
        $display("Test pump done");

        ovComp <= 1'b1;
        tick(5);
        chk({sdoEn, ovLatch}, 2'h1, "ov off");
        ovComp <= 1'b0;
        tick(5);
        chk(sdoEn, 1'b0, "ov waits select");
        frame(1'b0);
        frame(1'b1);
        tick(5);
        chk(sdoEn, 1'b0, "sdo off deselected");
        clr(5'h02);
        chk(ovLatch, 1'b0, "ov clear");
        $display("Test serial out done");

        extRstN <= 1'b0;
        tick(5);
        chk({intRst, pumpEn, olEn}, 3'h4, "ext reset");
        chk({triState, driveOn}, 16'hFF00, "ext reset off");
        chk(extLatch, 1'b1, "ext latch");
        extRstN <= 1'b1;
        tick(5);
        chk({intRst, triState}, 9'h0FF, "ext released");
        clr(5'h08);
        chk(extLatch, 1'b0, "ext clear");
        $display("Test external reset done");

        cfg(8'hFF, 8'h00, 8'h00, 16'h0000);
        rst_n <= 1'b0;
        tick(2);
        chk({pumpEn, olEn, triState}, 10'h0FF, "power reset");
        rst_n <= 1'b1;
        tick(4);
        chk(porLatch, 1'b1, "power-on again");
        $display("Test power reset done");
        give_verdict();
    end
endmodule // predriver_ctrl_tb
`default_nettype wire
